// ===== logic/dsl_pkg.sv
// Shared constants and state types for the serial DAC load link
package dsl_pkg;
  localparam int              WORD_W      = 16;                 // Code bits per device
  localparam int              CHAIN_N     = 2;                  // Devices served by the host end
  localparam int              CHAIN_W     = WORD_W * CHAIN_N;   // Bits per chained load
  localparam logic [15:0]     CODE_RST    = 16'h0000;           // Shift and hold value after reset
  // Asynchronous receiver, sixteen samples per bit
  localparam logic [3:0]      RX_MID      = 4'h7;               // Samples from edge to start-bit middle minus one
  localparam logic [3:0]      RX_LAST     = 4'hF;               // Samples per bit minus one
  localparam logic [4:0]      RX_DATA_LST = 5'h0F;              // Index of last data bit
  // Host clock generation from the reference clock
  localparam int              REF_HZ      = 100_000_000;        // Reference clock rate
  localparam int              ASYNC_BPS   = 150_000;            // Highest asynchronous bit rate
  localparam int              ASYNC_CLK_HZ = ASYNC_BPS * 16;    // Link clock in asynchronous mode
  localparam int              SYNC_CLK_HZ = 10_000_000;         // Link clock in three-wire mode
  localparam int              ASYNC_HALF_I = (REF_HZ + 2 * ASYNC_CLK_HZ - 1) / (2 * ASYNC_CLK_HZ);
  localparam int              SYNC_HALF_I = (REF_HZ + 2 * SYNC_CLK_HZ - 1) / (2 * SYNC_CLK_HZ);
  localparam logic [7:0]      ASYNC_HALF  = 8'(ASYNC_HALF_I - 1); // Last divider count, async
  localparam logic [7:0]      SYNC_HALF   = 8'(SYNC_HALF_I - 1);  // Last divider count, three-wire
  localparam logic [3:0]      SUB_TW      = 4'h0;               // Clock periods per bit minus one, three-wire
  localparam logic [5:0]      TW_LEFT     = 6'h1F;              // Bits after the first, three-wire
  localparam logic [5:0]      AS_LEFT     = 6'h11;              // Bits after the start bit, async
  localparam logic [14:0]     AS_PAD      = 15'h7FFF;           // Idle-high fill behind the stop bit

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } dsl_rx_type;

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_SETUP = 4'b0010,
    H_SHIFT = 4'b0100,
    H_LOAD  = 4'b1000
  } dsl_host_type;
endpackage

// ===== logic/dsl_link_if.sv
// Serial link between the host end and the converter end
`timescale 1ns/10ps
interface dsl_link_if;
  logic sclk;      // Link clock, made by the host
  logic sdi;       // Serial data toward the device
  logic latch_o;   // Load strobe level driven by the host
  logic latch_oe;  // High while the host drives the strobe
  logic latch;     // Strobe as seen at the device pin
  logic sdo;       // Chain output of the device

  // Released strobe floats up through the pull-up resistor
  assign latch = latch_oe ? latch_o : 1'b1;

  modport host (output sclk, output sdi, output latch_o, output latch_oe);
  modport dev  (input sclk, input sdi, input latch, output sdo);
endinterface

// ===== logic/dsl_dev.sv
// Converter-end serial input logic: shift register, chain output, load and async receiver
// Behaviour
// - Sixteen-bit shift register per device
// - Bits leaving register drive chain output
// - Chain acts as one register; far first
// - Shared strobe loads every device together
// - Undriven pulled-up strobe selects asynchronous mode
// - Async link clock is sixteen times bitrate
// - Async rate at most 150 kbit/s
// - Host sends upper byte then lower byte
// - Strobe low before and during transfer
// - Eight clocks per byte, data valid rising
// - Strobe rise after full word loads it
// - Shift data in on rising clock
// - Strobe copies register into holding latch
// - Clock idle while converter is updated
// - Async frame start/stop; frame triggers load
`timescale 1ns/10ps
module dsl_dev (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst,
  dsl_link_if.dev                         link,
  output logic [dsl_pkg::WORD_W-1:0]      o_dac_code,
  output logic                            o_update,
  output logic                            o_async_mode
);

  // Link clock domain
  logic                        rst_m_q;    // Reset synchroniser, first stage
  logic                        rst_s_q;    // Reset in link domain
  logic [dsl_pkg::WORD_W-1:0]  shreg_q;    // Input shift register
  logic [dsl_pkg::WORD_W-1:0]  shreg_d;
  logic                        rxm_q;      // Data synchroniser, first stage
  logic                        rxs_q;      // Data synchroniser, second stage
  dsl_pkg::dsl_rx_type         rx_st_q;    // Receiver state
  dsl_pkg::dsl_rx_type         rx_st_d;
  logic [3:0]                  tick_q;     // Sample counter within a bit
  logic [3:0]                  tick_d;
  logic [4:0]                  bits_q;     // Data bit index
  logic [4:0]                  bits_d;
  logic [dsl_pkg::WORD_W-1:0]  rxsh_q;     // Receiver assembly register
  logic [dsl_pkg::WORD_W-1:0]  rxsh_d;
  logic [dsl_pkg::WORD_W-1:0]  word_q;     // Last good async word
  logic [dsl_pkg::WORD_W-1:0]  word_d;
  logic                        tgl_q;      // Flips once per good frame
  logic                        tgl_d;

  // Reference clock domain
  logic                        lat_m_q;    // Strobe synchroniser, first stage
  logic                        lat_s_q;    // Strobe synchroniser, second stage
  logic                        lat_p_q;    // Strobe one cycle earlier
  logic                        tg_m_q;     // Frame toggle synchroniser, first stage
  logic                        tg_s_q;     // Frame toggle synchroniser, second stage
  logic                        tg_p_q;     // Toggle one cycle earlier
  logic                        async_q;    // Async mode flag, cleared for good by a low strobe
  logic [dsl_pkg::WORD_W-1:0]  hold_q;     // Holding latch feeding the converter
  logic [dsl_pkg::WORD_W-1:0]  hold_d;
  logic                        upd_q;      // One-cycle update pulse

  // Decode in the reference domain
  wire lat_rise = lat_s_q & ~lat_p_q;
  wire frame_evt = tg_s_q ^ tg_p_q;
  wire load_tw = lat_rise & ~async_q;
  wire load_as = frame_evt & async_q;

  // Shift toward the MSB so the first bit in ends at the top
  assign shreg_d = {shreg_q[dsl_pkg::WORD_W-2:0], link.sdi};

  // Chain output is the bit falling off the top of the register
  assign link.sdo = shreg_q[dsl_pkg::WORD_W-1];

  // Reset carried into the link domain; needs link clock edges to take effect
  always_ff @(posedge link.sclk)
  begin
    rst_m_q <= i_rst;
    rst_s_q <= rst_m_q;
  end

  // Shift register runs on every rising link clock in either mode
  always_ff @(posedge link.sclk)
  begin
    if (rst_s_q)
    begin
      shreg_q <= dsl_pkg::CODE_RST;
    end
    else
    begin
      shreg_q <= shreg_d;
    end
  end

  // Async data is free-running relative to the sample clock, so it is synchronised
  always_ff @(posedge link.sclk)
  begin
    rxm_q <= link.sdi;
    rxs_q <= rxm_q;
  end

  // Receiver next state: start edge, mid-bit samples, stop check
  always_comb
  begin
    rx_st_d = rx_st_q;
    tick_d  = tick_q + 4'h1;
    bits_d  = bits_q;
    rxsh_d  = rxsh_q;
    word_d  = word_q;
    tgl_d   = tgl_q;
    unique case (rx_st_q)
      dsl_pkg::RX_IDLE:
      begin
        // Wait for the falling start edge
        tick_d = 4'h0;
        if (!rxs_q)
        begin
          rx_st_d = dsl_pkg::RX_START;
        end
      end
      dsl_pkg::RX_START:
      begin
        // Recheck at mid start bit; a glitch returns to idle
        if (tick_q == dsl_pkg::RX_MID)
        begin
          tick_d  = 4'h0;
          bits_d  = 5'h00;
          rx_st_d = rxs_q ? dsl_pkg::RX_IDLE : dsl_pkg::RX_DATA;
        end
      end
      dsl_pkg::RX_DATA:
      begin
        // Counter wraps every sixteen samples, landing mid-bit
        if (tick_q == dsl_pkg::RX_LAST)
        begin
          rxsh_d = {rxsh_q[dsl_pkg::WORD_W-2:0], rxs_q};
          bits_d = bits_q + 5'h01;
          if (bits_q == dsl_pkg::RX_DATA_LST)
          begin
            rx_st_d = dsl_pkg::RX_STOP;
          end
        end
      end
      dsl_pkg::RX_STOP:
      begin
        // A low stop bit discards the whole frame
        if (tick_q == dsl_pkg::RX_LAST)
        begin
          rx_st_d = dsl_pkg::RX_IDLE;
          if (rxs_q)
          begin
            word_d = rxsh_q;
            tgl_d  = ~tgl_q;
          end
        end
      end
    endcase
  end

  // Receiver registers
  always_ff @(posedge link.sclk)
  begin
    if (rst_s_q)
    begin
      rx_st_q <= dsl_pkg::RX_IDLE;
      tick_q  <= 4'h0;
      bits_q  <= 5'h00;
      rxsh_q  <= dsl_pkg::CODE_RST;
      word_q  <= dsl_pkg::CODE_RST;
      tgl_q   <= 1'b0;
    end
    else
    begin
      rx_st_q <= rx_st_d;
      tick_q  <= tick_d;
      bits_q  <= bits_d;
      rxsh_q  <= rxsh_d;
      word_q  <= word_d;
      tgl_q   <= tgl_d;
    end
  end

  // Strobe and frame toggle synchronisers; strobe idles high like its pull-up
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      lat_m_q <= 1'b1;
      lat_s_q <= 1'b1;
      lat_p_q <= 1'b1;
      tg_m_q  <= 1'b0;
      tg_s_q  <= 1'b0;
      tg_p_q  <= 1'b0;
    end
    else
    begin
      lat_m_q <= link.latch;
      lat_s_q <= lat_m_q;
      lat_p_q <= lat_s_q;
      tg_m_q  <= tgl_q;
      tg_s_q  <= tg_m_q;
      tg_p_q  <= tg_s_q;
    end
  end

  // Mode: async until the strobe is ever seen driven low; kept as a flop so the output needs no gate
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      async_q <= 1'b1;
    end
    else if (!lat_s_q)
    begin
      async_q <= 1'b0;
    end
  end

  // Holding latch source. The shift register and async word are read across
  // domains: both stand still while the load is taken (idle clock, or toggle
  // arriving after the word was written), so no bit can be caught mid-change.
  assign hold_d = load_tw ? shreg_q : (load_as ? word_q : hold_q);

  // Holding latch and update pulse
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      hold_q <= dsl_pkg::CODE_RST;
      upd_q  <= 1'b0;
    end
    else
    begin
      hold_q <= hold_d;
      upd_q  <= load_tw | load_as;
    end
  end

  // User-side outputs straight from flops
  assign o_dac_code   = hold_q;
  assign o_update     = upd_q;
  assign o_async_mode = async_q;

endmodule // dsl_dev

// ===== logic/dsl_host.sv
// Host end: makes the link clock, shifts codes out, drives or releases the strobe
`timescale 1ns/10ps
module dsl_host (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_async,
  input  wire logic                        i_valid,
  input  wire logic [dsl_pkg::CHAIN_W-1:0] i_data,
  output logic                             o_ready,
  output logic                             o_done,
  dsl_link_if.host                         link
);

  logic [7:0]                  div_q;      // Half-period divider
  logic                        sclk_q;     // Link clock
  logic [3:0]                  sub_q;      // Clock periods within a bit
  logic [5:0]                  left_q;     // Bits still to send
  logic [5:0]                  left_d;
  logic [dsl_pkg::CHAIN_W-1:0] tx_q;       // Outgoing bits, MSB next
  logic [dsl_pkg::CHAIN_W-1:0] tx_d;
  logic                        sdi_q;      // Bit on the data line
  logic                        sdi_d;
  logic                        lat_q;      // Strobe level
  logic                        lat_d;
  logic                        mode_q;     // Async when high
  logic                        done_q;
  logic                        done_d;
  logic                        ready_q;
  dsl_pkg::dsl_host_type       st_q;
  dsl_pkg::dsl_host_type       st_d;

  // Clock timing decode
  wire [7:0] half = mode_q ? dsl_pkg::ASYNC_HALF : dsl_pkg::SYNC_HALF;
  wire tick = (div_q == half);
  wire run = mode_q | (st_q == dsl_pkg::H_SHIFT);
  wire fall = tick & sclk_q;
  wire [3:0] sub_last = mode_q ? dsl_pkg::RX_LAST : dsl_pkg::SUB_TW;
  wire bit_end = fall & (sub_q == sub_last);
  wire accept = i_valid & ready_q;
  // Async frames start on a bit boundary, else the start bit would be cut short
  wire start_ev = mode_q ? bit_end : tick;

  // Transfer sequencing
  always_comb
  begin
    st_d   = st_q;
    left_d = left_q;
    tx_d   = tx_q;
    sdi_d  = sdi_q;
    lat_d  = lat_q;
    done_d = 1'b0;
    unique case (st_q)
      dsl_pkg::H_IDLE:
      begin
        if (accept)
        begin
          st_d  = dsl_pkg::H_SETUP;
          lat_d = mode_q;
          // Three-wire: far device's code sits on top and leaves first; async sends only the i_data low word
          tx_d  = mode_q ? {i_data[dsl_pkg::WORD_W-1:0], 1'b1, dsl_pkg::AS_PAD} : i_data;
        end
      end
      dsl_pkg::H_SETUP:
      begin
        if (start_ev)
        begin
          st_d = dsl_pkg::H_SHIFT;
          if (mode_q)
          begin
            sdi_d  = 1'b0;
            left_d = dsl_pkg::AS_LEFT;
          end
          else
          begin
            sdi_d  = tx_q[dsl_pkg::CHAIN_W-1];
            tx_d   = {tx_q[dsl_pkg::CHAIN_W-2:0], 1'b1};
            left_d = dsl_pkg::TW_LEFT;
          end
        end
      end
      dsl_pkg::H_SHIFT:
      begin
        // New bit on falling edge, stable across the next rise
        if (bit_end)
        begin
          if (left_q == 6'h00)
          begin
            st_d = dsl_pkg::H_LOAD;
          end
          else
          begin
            sdi_d  = tx_q[dsl_pkg::CHAIN_W-1];
            tx_d   = {tx_q[dsl_pkg::CHAIN_W-2:0], 1'b1};
            left_d = left_q - 6'h01;
          end
        end
      end
      dsl_pkg::H_LOAD:
      begin
        // Three-wire: strobe rises half a period after the last clock, clock idle
        if (tick)
        begin
          st_d   = dsl_pkg::H_IDLE;
          lat_d  = 1'b1;
          sdi_d  = 1'b1;
          done_d = 1'b1;
        end
      end
    endcase
  end

  // Clock divider; in three-wire the clock rests low outside the shift phase
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      div_q  <= 8'h00;
      sclk_q <= 1'b0;
      sub_q  <= 4'h0;
    end
    else
    begin
      div_q  <= tick ? 8'h00 : div_q + 8'h01;
      sclk_q <= tick ? (run & ~sclk_q) : sclk_q;
      sub_q  <= (bit_end | ~run) ? 4'h0 : (fall ? sub_q + 4'h1 : sub_q);
    end
  end

  // Sequencer registers; mode only changes between transfers
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st_q    <= dsl_pkg::H_IDLE;
      left_q  <= 6'h00;
      tx_q    <= {dsl_pkg::CHAIN_W{1'b1}};
      sdi_q   <= 1'b1;
      lat_q   <= 1'b1;
      mode_q  <= 1'b0;
      done_q  <= 1'b0;
      ready_q <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      left_q  <= left_d;
      tx_q    <= tx_d;
      sdi_q   <= sdi_d;
      lat_q   <= lat_d;
      mode_q  <= (st_q == dsl_pkg::H_IDLE) ? i_async : mode_q;
      done_q  <= done_d;
      ready_q <= (st_d == dsl_pkg::H_IDLE) & ~accept;
    end
  end

  // Link and user outputs from flops, latch_oe through an inverter on mode_q; async mode releases the strobe
  assign link.sclk     = sclk_q;
  assign link.sdi      = sdi_q;
  assign link.latch_o  = lat_q;
  assign link.latch_oe = ~mode_q;
  assign o_ready       = ready_q;
  assign o_done        = done_q;

endmodule // dsl_host

// ===== verification/dsl_props.sv
// Interface checker for the serial converter load link
`timescale 1ns/10ps
module dsl_props (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic sclk,
  input  wire logic sdi,
  input  wire logic latch_o,
  input  wire logic latch_oe,
  input  wire logic latch,
  input  wire logic sdo
);
  localparam int TW_HI = dsl_pkg::SYNC_HALF_I;   // Ref cycles per high phase, three-wire
  localparam int AS_HI = dsl_pkg::ASYNC_HALF_I;  // Ref cycles per high phase, async

  logic       sclk_q;            // Link clock one ref cycle late
  logic [5:0] bits_q;            // Link rises while strobe low
  logic [7:0] hi_q;              // Ref cycles of current high phase
  logic [4:0] rise_q  = 5'h00;   // Link rises seen, saturating
  logic       sdi_s_q = 1'b1;    // Data at previous link rise
  logic       oe_s_q  = 1'b1;    // Strobe enable at previous link rise
  logic [8:0] run_q   = 9'h000;  // Link rises since data last changed

  // Ref-domain counters
  always_ff @(posedge i_ref_clk)
  begin
    sclk_q <= sclk;
    bits_q <= (i_rst || latch) ? 6'h00 : bits_q + 6'(sclk && !sclk_q);
    hi_q   <= (i_rst || !sclk) ? 8'h00 : hi_q + 8'h01;
  end

  // Link-domain history; the count restarts while reset is seen, so the device reset pipeline drains first
  always_ff @(posedge sclk)
  begin
    rise_q  <= i_rst ? 5'h00 : ((rise_q == 5'h12) ? rise_q : rise_q + 5'h01);
    sdi_s_q <= sdi;
    oe_s_q  <= latch_oe;
    run_q   <= (sdi != sdi_s_q) ? 9'h000 : run_q + 9'h001;
  end

  AST_SDO_DELAY : assert property (@(posedge sclk) disable iff (i_rst)
    rise_q == 5'h12 |-> sdo == $past(sdi, 16))
    else $error("chain output is not the bit taken sixteen rises earlier");
  AST_STROBE_LOW_SHIFT : assert property (@(posedge sclk) disable iff (i_rst)
    latch_oe |-> !latch_o)
    else $error("link clock rose while the strobe was high");
  AST_HALF_PERIOD : assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(sclk) |-> hi_q == (latch_oe ? 8'(TW_HI) : 8'(AS_HI)))
    else $error("link clock high phase has the wrong length");
  AST_DATA_STABLE : assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(sclk) |-> $stable(sdi) ##1 $stable(sdi))
    else $error("data moved around a rising link clock");
  AST_IDLE_AFTER_LOAD : assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(latch) |-> !sclk ##1 !sclk [*4])
    else $error("link clock active during the load");
  AST_BIT_COUNT : assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(latch) |-> bits_q == 6'(dsl_pkg::CHAIN_W))
    else $error("strobe rose after the wrong number of bits");
  AST_SETUP_BEFORE_CLOCK : assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(latch) |-> !sclk [*4])
    else $error("link clock started too soon after the strobe fell");
  AST_ASYNC_BIT_LEN : assert property (@(posedge sclk) disable iff (i_rst)
    !latch_oe && !oe_s_q && sdi && !sdi_s_q |-> run_q[3:0] == 4'hF)
    else $error("async low run is not a whole number of bits");

  // Main scenarios reached
  COV_LOAD : cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(latch));
  COV_ASYNC_EDGE : cover property (@(posedge sclk) disable iff (i_rst) !latch_oe && sdi && !sdi_s_q);
  COV_ASYNC_CLK : cover property (@(posedge i_ref_clk) disable iff (i_rst) !latch_oe && $fell(sclk));
endmodule // dsl_props

// ===== verification/tb.sv
// Bench: host end driving two chained ends, plus a bench-driven async end
`timescale 1ns/10ps
module tb;
  logic        ref_clk = 1'b0;          // 100 MHz reference
  logic        rst     = 1'b1;          // Synchronous reset
  logic        asy     = 1'b0;          // Host mode select
  logic        vld     = 1'b0;          // Host request
  logic [31:0] dat     = 32'h00000000;  // Host chain word
  logic        sclk_c  = 1'b0;          // Bench link clock, async end
  logic        sdi_c   = 1'b1;          // Bench data, async end
  logic        chk_ab  = 1'b1;          // Chained ends watched
  logic        rdy;                     // Host idle
  logic        done;                    // Host finished
  logic [31:0] wire_q;                  // Last 32 bits on the wire
  logic [15:0] code_a;                  // Near end code
  logic [15:0] code_b;                  // Far end code
  logic [15:0] code_c;                  // Async end code
  logic        upd_a;                   // Near end load pulse
  logic        upd_b;                   // Far end load pulse
  logic        upd_c;                   // Async end load pulse
  logic        mode_a;                  // Near end async flag
  logic        mode_c;                  // Async end async flag
  logic [15:0] qa[$];                   // Expected near codes
  logic [15:0] qb[$];                   // Expected far codes
  logic [15:0] qc[$];                   // Expected async codes
  int          errors  = 0;             // Mismatches
  int          checked = 0;             // Comparisons
  int          cycles  = 0;             // Hang guard

  dsl_link_if lnk_a ();
  dsl_link_if lnk_b ();
  dsl_link_if lnk_c ();

  // Far end shares clock and strobe, takes data from the near end
  assign lnk_b.sclk     = lnk_a.sclk;
  assign lnk_b.sdi      = lnk_a.sdo;
  assign lnk_b.latch_o  = lnk_a.latch_o;
  assign lnk_b.latch_oe = lnk_a.latch_oe;
  // Async end: strobe released, so the pull-up selects async
  assign lnk_c.sclk     = sclk_c;
  assign lnk_c.sdi      = sdi_c;
  assign lnk_c.latch_o  = 1'b1;
  assign lnk_c.latch_oe = 1'b0;

  dsl_host u_dsl_host (.i_ref_clk(ref_clk), .i_rst(rst), .i_async(asy), .i_valid(vld), .i_data(dat),
                       .o_ready(rdy), .o_done(done), .link(lnk_a.host));
  dsl_dev u_dsl_dev_a (.i_ref_clk(ref_clk), .i_rst(rst), .link(lnk_a.dev), .o_dac_code(code_a),
                       .o_update(upd_a), .o_async_mode(mode_a));
  dsl_dev u_dsl_dev_b (.i_ref_clk(ref_clk), .i_rst(rst), .link(lnk_b.dev), .o_dac_code(code_b),
                       .o_update(upd_b), .o_async_mode());
  dsl_dev u_dsl_dev_c (.i_ref_clk(ref_clk), .i_rst(rst), .link(lnk_c.dev), .o_dac_code(code_c),
                       .o_update(upd_c), .o_async_mode(mode_c));
  dsl_props u_dsl_props (.i_ref_clk(ref_clk), .i_rst(rst), .sclk(lnk_a.sclk), .sdi(lnk_a.sdi),
                         .latch_o(lnk_a.latch_o), .latch_oe(lnk_a.latch_oe), .latch(lnk_a.latch),
                         .sdo(lnk_a.sdo));

  // Clocks; the bench link clock has its own phase
  always #5 ref_clk = ~ref_clk;
  initial
  begin
    #3;
    forever #15 sclk_c = ~sclk_c;
  end

  // Wire history, read after each three-wire transfer
  always @(posedge lnk_a.sclk)
    wire_q <= {wire_q[30:0], lnk_a.sdi};

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One host request; a second request while busy must be ignored
  task automatic send(input logic [31:0] d);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    vld <= 1'b1;
    dat <= d;
    if (!asy)
    begin
      qa.push_back(d[15:0]);
      qb.push_back(d[31:16]);
    end
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
      vld <= (n == 40);
      if (n == 40)
        dat <= ~d;
    end
    while (done !== 1'b1 && n < 15000);
    check("done", 32'(done), 32'h1);
    if (!asy)
      check("wire_bits", wire_q, d);
  endtask

  // Samples the host async frame at bit middles
  task automatic grab(input logic [15:0] d);
    logic [17:0] f;
    f = '0;
    wait (lnk_a.sdi === 1'b0);
    repeat (8) @(posedge lnk_a.sclk);
    for (int k = 0; k < 18; k++)
    begin
      f = {f[16:0], lnk_a.sdi};
      if (k < 17)
        repeat (16) @(posedge lnk_a.sclk);
    end
    check("async_frame", 32'(f), {14'h0000, 1'b0, d, 1'b1});
  endtask

  // Bench async frame, sixteen link clocks per bit, chosen stop level
  task automatic frame_c(input logic [15:0] d, input logic stop);
    logic [17:0] f;
    f = {1'b0, d, stop};
    if (stop)
      qc.push_back(d);
    for (int k = 17; k >= 0; k--)
    begin
      @(posedge sclk_c);
      sdi_c <= f[k];
      repeat (15) @(posedge sclk_c);
    end
    @(posedge sclk_c);
    sdi_c <= 1'b1;
    repeat (48) @(posedge sclk_c);
  endtask

  // Result watcher: oldest note against each load pulse
  always @(posedge ref_clk)
  begin
    if (chk_ab && upd_a === 1'b1)
    begin
      check("upd_b", 32'(upd_b), 32'h1);
      if (qa.size() > 0)
        check("code_a", 32'(code_a), 32'(qa.pop_front()));
      else
        check("extra_a", 32'h1, 32'h0);
      if (qb.size() > 0)
        check("code_b", 32'(code_b), 32'(qb.pop_front()));
    end
    else if (chk_ab && upd_b === 1'b1)
      check("upd_a", 32'h0, 32'h1);
    if (upd_c === 1'b1)
    begin
      if (qc.size() > 0)
        check("code_c", 32'(code_c), 32'(qc.pop_front()));
      else
        check("extra_c", 32'h1, 32'h0);
    end
  end

  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      test_done();
    end
  end

  // Main sequence
  initial
  begin
    logic [31:0] r;
    r = $urandom(41);
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    send(32'hFFFF0001);
    send($urandom());
    send($urandom());
    check("mode_a", 32'(mode_a), 32'h0);
    frame_c(16'h8001, 1'b1);
    frame_c(16'($urandom()), 1'b0);
    frame_c(16'($urandom()), 1'b1);
    check("mode_c", 32'(mode_c), 32'h1);
    repeat (50) @(posedge ref_clk);
    // Chained ends have no clean async receiver after this reset
    chk_ab = 1'b0;
    asy <= 1'b1;
    rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    r = $urandom();
    fork
      send(r);
      grab(r[15:0]);
    join
    check("pending", 32'(qa.size() + qb.size() + qc.size()), 32'h0);
    test_done();
  end
endmodule // tb
